// [verilog/vlan_diffserv_table_access.sv]
// axi4-lite register slave for the vlan read-back and priority map tables
// assumes the vlan command source runs on aclk; one write and one read at a time
//
// Operation
// - vlan read data in bits 17:0, zero reset
// - default table: id 11:0, priority 14:12
// - untagged or null frames take port defaults
// - vlan entry: member/untag pairs, id 11:0
// - member port accepts, joins egress domain
// - non-member drops unless admitted, excluded egress
// - untag bit strips tag on hybrid egress
// - vlan pending bit self-clears after command
// - command write launches one table access
// - bit 7 selects read or write
// - bits 5:0 index sixty-four entries
// - write data priority stored by write
// - read data shows indexed priority
// - separate self-clearing priority pending flag
`timescale 1ns/1ps
`default_nettype none
module vlan_diffserv_table_access
  import vlan_diffserv_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // vlan table command from the command register
  input wire logic vlan_table_command,
  input wire logic vlan_cmd_rnw,
  input wire logic table_select,
  input wire logic [VLAN_IDX_W-1:0] vlan_cmd_index,
  input wire logic [VLAN_DATA_W-1:0] vlan_cmd_wdata,
  // ingress configuration
  input wire logic [NUM_PORTS-1:0] admit_non_member_setting,
  input wire logic [NUM_PORTS-1:0] egress_port_type_setting,
  // vlan ingress lookup
  input wire logic lkp_valid,
  input wire logic [1:0] lkp_port,
  input wire logic lkp_tagged,
  input wire logic [VID_W-1:0] lkp_vid,
  input wire logic [PRIO_W-1:0] lkp_tag_prio,
  output logic res_valid,
  output logic res_accept,
  output logic [NUM_PORTS-1:0] res_egress_mask,
  output logic [NUM_PORTS-1:0] res_strip_mask,
  output logic [VID_W-1:0] res_vid,
  output logic [PRIO_W-1:0] res_prio,
  // code point lookup
  input wire logic [PMAP_IDX_W-1:0] cp_index,
  output logic [PRIO_W-1:0] cp_prio
);
  localparam int LAUNCH_WAIT = 1;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = ADDR_W'({idx[13:0], 2'b00});
  endfunction

  // merge written bytes into an old value
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge_strb[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

  // write channel capture
  logic aw_have_reg; // address held
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_have_reg; // data held
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  // read channel
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  // software registers
  logic cmd_rnw_reg; // direction bit
  logic [PMAP_IDX_W-1:0] cmd_idx_reg; // entry index
  logic [PRIO_W-1:0] pmap_wdata_reg; // write priority
  // table status
  logic pmap_pending;
  logic [PRIO_W-1:0] pmap_read_prio;
  logic vlan_pending;
  logic [VLAN_DATA_W-1:0] vlan_read_data;

  // write decode, performed the cycle after both halves are held
  wire do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  wire wr_cmd = (aw_addr_reg == byte_addr(IDX_PMAP_CMD));
  wire wr_wdat = (aw_addr_reg == byte_addr(IDX_PMAP_WR_DATA));
  wire wr_ro = (aw_addr_reg == byte_addr(IDX_VLAN_RD_DATA))
               || (aw_addr_reg == byte_addr(IDX_VLAN_CMD_STS))
               || (aw_addr_reg == byte_addr(IDX_PMAP_RD_DATA))
               || (aw_addr_reg == byte_addr(IDX_PMAP_CMD_STS));
  wire wr_mapped = wr_cmd || wr_wdat || wr_ro;
  wire [31:0] cmd_cur = {24'h000000, cmd_rnw_reg, 1'b0, cmd_idx_reg};
  wire [31:0] cmd_new = merge_strb(cmd_cur, w_data_reg, w_strb_reg);
  wire [31:0] wdat_new = merge_strb({29'h0, pmap_wdata_reg}, w_data_reg, w_strb_reg);
  wire pmap_launch = do_write && wr_cmd;

  // read decode
  wire ar_take = arvalid && !rvalid_reg;
  wire rd_vdat = (araddr == byte_addr(IDX_VLAN_RD_DATA));
  wire rd_vsts = (araddr == byte_addr(IDX_VLAN_CMD_STS));
  wire rd_cmd = (araddr == byte_addr(IDX_PMAP_CMD));
  wire rd_wdat = (araddr == byte_addr(IDX_PMAP_WR_DATA));
  wire rd_rdat = (araddr == byte_addr(IDX_PMAP_RD_DATA));
  wire rd_psts = (araddr == byte_addr(IDX_PMAP_CMD_STS));
  wire rd_mapped = rd_vdat || rd_vsts || rd_cmd || rd_wdat || rd_rdat || rd_psts;
  wire [31:0] rd_mux =
    rd_vdat ? {14'h0000, vlan_read_data} :
    rd_vsts ? {31'h0, vlan_pending} :
    rd_cmd ? cmd_cur :
    rd_wdat ? {29'h0, pmap_wdata_reg} :
    rd_rdat ? {29'h0, pmap_read_prio} :
    rd_psts ? {31'h0, pmap_pending} :
    32'h00000000;

  // write address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // write response, unmapped addresses answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // software registers, reserved bit 6 never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_rnw_reg <= 1'b0;
      cmd_idx_reg <= RST_PMAP_IDX;
      pmap_wdata_reg <= RST_PRIO;
    end else if (do_write) begin
      if (wr_cmd) begin
        cmd_rnw_reg <= cmd_new[CMD_RNW_BIT];
        cmd_idx_reg <= cmd_new[PMAP_IDX_W-1:0];
      end
      if (wr_wdat) begin
        pmap_wdata_reg <= wdat_new[PRIO_W-1:0];
      end
    end
  end

  // read data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // code point priority table
  priority_map_table u_pmap (
    .aclk(aclk),
    .aresetn(aresetn),
    .launch(pmap_launch),
    .launch_rnw(cmd_new[CMD_RNW_BIT]),
    .launch_index(cmd_new[PMAP_IDX_W-1:0]),
    .launch_prio(pmap_wdata_reg),
    .pending(pmap_pending),
    .read_prio(pmap_read_prio),
    .lkp_index(cp_index),
    .lkp_prio(cp_prio)
  );

  // vlan and default id tables
  vlan_table u_vlan (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmd_valid(vlan_table_command),
    .cmd_rnw(vlan_cmd_rnw),
    .table_select(table_select),
    .cmd_index(vlan_cmd_index),
    .cmd_wdata(vlan_cmd_wdata),
    .pending(vlan_pending),
    .read_data(vlan_read_data),
    .admit_non_member_setting(admit_non_member_setting),
    .egress_port_type_setting(egress_port_type_setting),
    .lkp_valid(lkp_valid),
    .lkp_port(lkp_port),
    .lkp_tagged(lkp_tagged),
    .lkp_vid(lkp_vid),
    .lkp_tag_prio(lkp_tag_prio),
    .res_valid(res_valid),
    .res_accept(res_accept),
    .res_egress_mask(res_egress_mask),
    .res_strip_mask(res_strip_mask),
    .res_vid(res_vid),
    .res_prio(res_prio)
  );

  // bus outputs
  assign awready = !aw_have_reg && !bvalid_reg;
  assign wready = !w_have_reg && !bvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // a command write raises pending on the next cycle when idle
  AST_CMD_LAUNCH_PENDING: assert property (@(posedge aclk) disable iff (!aresetn)
    (pmap_launch && !pmap_pending) |-> ##LAUNCH_WAIT pmap_pending)
    else $error("command write did not raise pending");
  // the status register read reflects the pending flag
  AST_PSTS_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rd_psts) |=> (rdata == {31'h0, $past(pmap_pending)}))
    else $error("priority status read wrong");
  // vlan read data has zero reserved bits
  AST_VLAN_RD_RESERVED: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rd_vdat) |=> (rdata[31:18] == 14'h0000))
    else $error("vlan read data reserved bits set");
  // command readback keeps bit 6 and upper bits zero
  AST_CMD_RESERVED: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rd_cmd) |=> (rdata[31:8] == 24'h000000 && !rdata[CMD_RSVD_BIT]))
    else $error("command reserved bits set");
  // a read command ends with the stored priority in the read data register
  AST_READ_RESULT: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pmap_pending) && cmd_rnw_reg |-> (pmap_read_prio == u_pmap.map_mem[cmd_idx_reg]))
    else $error("read result mismatch");
  // the write response follows the write by exactly one cycle
  AST_BRESP_TIMING: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> (bvalid && bresp == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write response timing wrong");
endmodule
`default_nettype wire

// [verilog/vlan_diffserv_pkg.sv]
// shared constants and types for the vlan / priority map table access block
// assumes a 32-bit axi4-lite register bus, printed offsets are word indexes
package vlan_diffserv_pkg;

  // register indexes as printed, byte address is four times the index
  localparam logic [15:0] IDX_VLAN_RD_DATA = 16'h180E;
  localparam logic [15:0] IDX_VLAN_CMD_STS = 16'h1810;
  localparam logic [15:0] IDX_PMAP_CMD = 16'h1811;
  localparam logic [15:0] IDX_PMAP_WR_DATA = 16'h1812;
  localparam logic [15:0] IDX_PMAP_RD_DATA = 16'h1813;
  localparam logic [15:0] IDX_PMAP_CMD_STS = 16'h1814;
  localparam int ADDR_W = 16;

  // field layout
  localparam int VLAN_DATA_W = 18;
  localparam int VID_W = 12;
  localparam int PVID_W = 15;
  localparam int PVID_PRIO_LSB = 12;
  localparam int UNTAG_P0_BIT = 12;
  localparam int MEMBER_P0_BIT = 13;
  localparam int NUM_PORTS = 3;
  localparam int VLAN_IDX_W = 4;
  localparam int VLAN_ENTRIES = 16;
  localparam int PRIO_W = 3;
  localparam int PMAP_IDX_W = 6;
  localparam int PMAP_ENTRIES = 64;
  localparam int CMD_RNW_BIT = 7;
  localparam int CMD_RSVD_BIT = 6;
  localparam int PENDING_BIT = 0;

  // reset values
  localparam logic [VLAN_DATA_W-1:0] RST_VLAN_RD_DATA = 18'h00000;
  localparam logic [PVID_W-1:0] RST_PVID = 15'h0000;
  localparam logic [PRIO_W-1:0] RST_PRIO = 3'h0;
  localparam logic [PMAP_IDX_W-1:0] RST_PMAP_IDX = 6'h00;

  // cycles a table access keeps its pending flag up
  localparam logic [1:0] OP_CYCLES = 2'h2;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // table access sequencer
  typedef enum logic {OP_IDLE, OP_BUSY} op_state_t;

endpackage

// [verilog/priority_map_table.sv]
// 64-entry code point to receive priority table with pending sequencer
// assumes launch is a one-cycle pulse from the register slave
`timescale 1ns/1ps
`default_nettype none
module priority_map_table
  import vlan_diffserv_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command from the register slave
  input wire logic launch,
  input wire logic launch_rnw,
  input wire logic [PMAP_IDX_W-1:0] launch_index,
  input wire logic [PRIO_W-1:0] launch_prio,
  // status and result
  output logic pending,
  output logic [PRIO_W-1:0] read_prio,
  // ingress lookup
  input wire logic [PMAP_IDX_W-1:0] lkp_index,
  output logic [PRIO_W-1:0] lkp_prio
);
  localparam int MAX_WAIT = 2;

  logic [PRIO_W-1:0] map_mem [PMAP_ENTRIES]; // table storage, no reset
  op_state_t state_reg; // sequencer state
  logic [1:0] cnt_reg; // cycles left
  logic rnw_reg; // latched direction
  logic [PMAP_IDX_W-1:0] idx_reg; // latched index
  logic [PRIO_W-1:0] prio_reg; // latched write priority
  logic [PRIO_W-1:0] read_prio_reg; // last read result
  logic [PRIO_W-1:0] lkp_prio_reg; // lookup result
  wire finish = (state_reg == OP_BUSY) && (cnt_reg == 2'h1); // last busy cycle

  // sequencer, pending rises the cycle after launch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= OP_IDLE;
      cnt_reg <= 2'h0;
      rnw_reg <= 1'b0;
      idx_reg <= RST_PMAP_IDX;
      prio_reg <= RST_PRIO;
      read_prio_reg <= RST_PRIO;
      lkp_prio_reg <= RST_PRIO;
    end else begin
      lkp_prio_reg <= map_mem[lkp_index];
      unique case (state_reg)
        OP_IDLE: begin
          if (launch) begin
            state_reg <= OP_BUSY;
            cnt_reg <= OP_CYCLES;
            rnw_reg <= launch_rnw;
            idx_reg <= launch_index;
            prio_reg <= launch_prio;
          end
        end
        OP_BUSY: begin
          cnt_reg <= cnt_reg - 2'h1;
          if (finish) begin // self clearing pending
            state_reg <= OP_IDLE;
            if (rnw_reg) begin
              read_prio_reg <= map_mem[idx_reg];
            end
          end
        end
      endcase
    end
  end

  // table write, contents undefined after power-up
  always_ff @(posedge aclk) begin
    if (finish && !rnw_reg) begin
      map_mem[idx_reg] <= prio_reg;
    end
  end

  assign pending = (state_reg == OP_BUSY);
  assign read_prio = read_prio_reg;
  assign lkp_prio = lkp_prio_reg;

  // a write command lands in the table entry when it finishes
  AST_PMAP_WRITE_STORES: assert property (@(posedge aclk) disable iff (!aresetn)
    (finish && !rnw_reg) |=> (map_mem[$past(idx_reg)] == $past(prio_reg)))
    else $error("priority map write not stored");
  // pending falls within the access time
  AST_PMAP_PENDING_ENDS: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pending) |-> ##[1:MAX_WAIT] !pending)
    else $error("priority map pending stuck");
endmodule
`default_nettype wire

// [verilog/vlan_table.sv]
// vlan membership table and per-port default id table with ingress lookup
// assumes the vlan command arrives as a one-cycle pulse from logic on aclk
`timescale 1ns/1ps
`default_nettype none
module vlan_table
  import vlan_diffserv_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // table command
  input wire logic cmd_valid,
  input wire logic cmd_rnw,
  input wire logic table_select,
  input wire logic [VLAN_IDX_W-1:0] cmd_index,
  input wire logic [VLAN_DATA_W-1:0] cmd_wdata,
  output logic pending,
  output logic [VLAN_DATA_W-1:0] read_data,
  // ingress configuration
  input wire logic [NUM_PORTS-1:0] admit_non_member_setting,
  input wire logic [NUM_PORTS-1:0] egress_port_type_setting,
  // ingress lookup request
  input wire logic lkp_valid,
  input wire logic [1:0] lkp_port,
  input wire logic lkp_tagged,
  input wire logic [VID_W-1:0] lkp_vid,
  input wire logic [PRIO_W-1:0] lkp_tag_prio,
  // ingress lookup result
  output logic res_valid,
  output logic res_accept,
  output logic [NUM_PORTS-1:0] res_egress_mask,
  output logic [NUM_PORTS-1:0] res_strip_mask,
  output logic [VID_W-1:0] res_vid,
  output logic [PRIO_W-1:0] res_prio
);
  logic [VLAN_DATA_W-1:0] vlan_mem [VLAN_ENTRIES]; // membership entries
  logic [PVID_W-1:0] pvid_mem [NUM_PORTS]; // per-port default id and priority
  op_state_t state_reg; // command sequencer
  logic [1:0] cnt_reg; // cycles left
  logic rnw_reg, sel_reg; // latched command
  logic [VLAN_IDX_W-1:0] idx_reg;
  logic [VLAN_DATA_W-1:0] wdata_reg;
  logic [VLAN_DATA_W-1:0] read_data_reg; // last read result
  logic res_valid_reg, res_accept_reg;
  logic [NUM_PORTS-1:0] res_egress_reg, res_strip_reg;
  logic [VID_W-1:0] res_vid_reg;
  logic [PRIO_W-1:0] res_prio_reg;
  logic hit; // matching entry found
  logic [VLAN_DATA_W-1:0] hit_entry;
  wire finish = (state_reg == OP_BUSY) && (cnt_reg == 2'h1);
  wire [1:0] port_sel = (lkp_port < 2'h3) ? lkp_port : 2'h0; // guard port 3
  wire [PVID_W-1:0] port_pvid = pvid_mem[port_sel];
  wire use_default = !lkp_tagged || (lkp_vid == 12'h000); // untagged or null id
  wire [VID_W-1:0] eff_vid = use_default ? port_pvid[VID_W-1:0] : lkp_vid;
  wire [PRIO_W-1:0] eff_prio = use_default ? port_pvid[PVID_W-1:PVID_PRIO_LSB] : lkp_tag_prio;
  wire [NUM_PORTS-1:0] members = {hit_entry[MEMBER_P0_BIT+4], hit_entry[MEMBER_P0_BIT+2],
                                  hit_entry[MEMBER_P0_BIT]};
  wire [NUM_PORTS-1:0] untags = {hit_entry[UNTAG_P0_BIT+4], hit_entry[UNTAG_P0_BIT+2],
                                 hit_entry[UNTAG_P0_BIT]};

  // search entries, id zero never matches
  always_comb begin
    hit = 1'b0;
    hit_entry = RST_VLAN_RD_DATA;
    for (int i = 0; i < VLAN_ENTRIES; i++) begin
      if (!hit && eff_vid != 12'h000 && vlan_mem[i][VID_W-1:0] == eff_vid) begin
        hit = 1'b1;
        hit_entry = vlan_mem[i];
      end
    end
  end

  // command sequencer and tables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= OP_IDLE;
      cnt_reg <= 2'h0;
      rnw_reg <= 1'b0;
      sel_reg <= 1'b0;
      idx_reg <= 4'h0;
      wdata_reg <= RST_VLAN_RD_DATA;
      read_data_reg <= RST_VLAN_RD_DATA;
      for (int i = 0; i < VLAN_ENTRIES; i++) vlan_mem[i] <= RST_VLAN_RD_DATA;
      for (int p = 0; p < NUM_PORTS; p++) pvid_mem[p] <= RST_PVID;
    end else begin
      unique case (state_reg)
        OP_IDLE: begin
          if (cmd_valid) begin
            state_reg <= OP_BUSY;
            cnt_reg <= OP_CYCLES;
            rnw_reg <= cmd_rnw;
            sel_reg <= table_select;
            idx_reg <= cmd_index;
            wdata_reg <= cmd_wdata;
          end
        end
        OP_BUSY: begin
          cnt_reg <= cnt_reg - 2'h1;
          if (finish) begin
            state_reg <= OP_IDLE;
            if (sel_reg && idx_reg < 4'h3) begin
              if (rnw_reg) read_data_reg <= {3'h0, pvid_mem[idx_reg[1:0]]};
              else pvid_mem[idx_reg[1:0]] <= wdata_reg[PVID_W-1:0];
            end else if (!sel_reg) begin
              if (rnw_reg) read_data_reg <= vlan_mem[idx_reg];
              else vlan_mem[idx_reg] <= wdata_reg;
            end else if (rnw_reg) begin
              read_data_reg <= RST_VLAN_RD_DATA;
            end
          end
        end
      endcase
    end
  end

  // registered ingress decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_valid_reg <= 1'b0;
      res_accept_reg <= 1'b0;
      res_egress_reg <= 3'h0;
      res_strip_reg <= 3'h0;
      res_vid_reg <= 12'h000;
      res_prio_reg <= RST_PRIO;
    end else begin
      res_valid_reg <= lkp_valid;
      res_accept_reg <= (hit && members[port_sel]) || admit_non_member_setting[port_sel];
      res_egress_reg <= hit ? members : 3'h0;
      res_strip_reg <= (hit && untags[port_sel]) ? egress_port_type_setting : 3'h0;
      res_vid_reg <= eff_vid;
      res_prio_reg <= eff_prio;
    end
  end

  assign pending = (state_reg == OP_BUSY);
  assign read_data = read_data_reg;
  assign res_valid = res_valid_reg;
  assign res_accept = res_accept_reg;
  assign res_egress_mask = res_egress_reg;
  assign res_strip_mask = res_strip_reg;
  assign res_vid = res_vid_reg;
  assign res_prio = res_prio_reg;

  // a member port is always accepted
  AST_VLAN_MEMBER_ACCEPT: assert property (@(posedge aclk) disable iff (!aresetn)
    (hit && members[port_sel]) |=> res_accept)
    else $error("member frame not accepted");
  // a non-member without admit is dropped and kept out of egress
  AST_VLAN_NONMEMBER_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    (!(hit && members[port_sel]) && !admit_non_member_setting[port_sel])
      |=> (!res_accept && !res_egress_mask[$past(port_sel)]))
    else $error("non-member frame not dropped");
  // pending follows a command by one cycle and lasts the access time
  AST_VLAN_PENDING: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_valid && !pending) |=> pending ##1 pending ##1 !pending)
    else $error("vlan pending timing wrong");
endmodule
`default_nettype wire

// [test/vlan_diffserv_table_access_tb.sv]
// bench for the vlan read-back and priority map register slave
// assumes the design package and modules are compiled first
`timescale 1ns/1ps
`default_nettype none
module vlan_diffserv_table_access_tb
  import vlan_diffserv_pkg::*;
;
  // bench-driven inputs
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic vcmd = 1'b0, vrnw = 1'b0, vsel = 1'b0, lkp_valid = 1'b0, lkp_tagged = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] vidx = 4'h0;
  logic [17:0] vwd = 18'h00000;
  logic [2:0] admit = 3'h0, ptype = 3'h4, lkp_tag_prio = 3'h6;
  logic [11:0] lkp_vid = 12'h005, res_vid;
  logic [1:0] lkp_port = 2'h0, rresp, rr, bresp;
  logic [5:0] cp_index = 6'h3F;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid, res_valid, res_accept;
  logic [2:0] res_prio, cp_prio, res_egress_mask, res_strip_mask;
  int num_errors = 0, n_compared = 0;

  vlan_diffserv_table_access uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(1'b1), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(1'b1),
    .rdata(rdata), .rresp(rresp), .vlan_table_command(vcmd), .vlan_cmd_rnw(vrnw),
    .table_select(vsel), .vlan_cmd_index(vidx), .vlan_cmd_wdata(vwd),
    .admit_non_member_setting(admit), .egress_port_type_setting(ptype), .lkp_valid(lkp_valid),
    .lkp_port(lkp_port), .lkp_tagged(lkp_tagged), .lkp_vid(lkp_vid),
    .lkp_tag_prio(lkp_tag_prio), .res_valid(res_valid), .res_accept(res_accept),
    .res_egress_mask(res_egress_mask), .res_strip_mask(res_strip_mask), .res_vid(res_vid),
    .res_prio(res_prio), .cp_index(cp_index), .cp_prio(cp_prio));

  // 200 mhz clock
  always #2.5 aclk = ~aclk;

  // compare and count
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", s, e, g);
      num_errors++;
    end
  endtask

  // axi write, entered just after a rising edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic aw, w, b;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
  endtask

  // axi read, data and response sampled at the falling edge where rvalid is high
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    logic ar, r;
    araddr <= a;
    arvalid <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      ar = arvalid && arready;
      r = rvalid;
      d = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end
  endtask

  task automatic ck(input string s, input logic [15:0] a, input logic [31:0] e);
    rd(a, v);
    chk(s, e, v);
  endtask

  // poll a pending flag until it drops
  task automatic pw(input logic [15:0] a);
    v = 32'h1;
    while (v[0] === 1'b1) rd(a, v);
  endtask

  // one-cycle vlan command pulse, pending seen on the next read
  task automatic vc(input logic r, input logic s, input logic [3:0] i, input logic [17:0] d);
    vcmd <= 1'b1;
    vrnw <= r;
    vsel <= s;
    vidx <= i;
    vwd <= d;
    @(posedge aclk);
    vcmd <= 1'b0;
    ck("vlan pending", 16'h6040, 32'h1);
    pw(16'h6040);
  endtask

  // lookup request, result one cycle later
  task automatic lk(input logic [1:0] p, input logic t, input logic [22:0] e);
    lkp_port <= p;
    lkp_tagged <= t;
    lkp_valid <= 1'b1;
    @(posedge aclk);
    lkp_valid <= 1'b0;
    @(negedge aclk);
    chk("lookup", {9'h0, e}, {9'h0, res_valid, res_accept, res_egress_mask,
      res_strip_mask, res_vid, res_prio});
    @(posedge aclk);
  endtask

  // reset values and an unmapped word
  task automatic t_reset;
    wr(16'h6054, 32'h1);
    chk("unmapped bresp", 32'(RESP_SLVERR), {30'h0, bresp});
    wr(16'h6038, 32'h3FFFF);
    chk("read-only bresp", 32'(RESP_OKAY), {30'h0, bresp});
    for (int i = 0; i < 8; i++) begin
      ck("reset value", 16'h6038 + 16'(i * 4), 32'h0);
    end
    chk("unmapped resp", 32'(RESP_SLVERR), {30'h0, rr});
  endtask

  // priority map write then read back, reserved bit set
  task automatic t_pmap;
    wr(16'h6048, 32'h5);
    wr(16'h6044, 32'h3F);
    ck("map pending", 16'h6050, 32'h1);
    pw(16'h6050);
    wr(16'h6044, 32'hFF);
    pw(16'h6050);
    ck("map command", 16'h6044, 32'hBF);
    ck("map read data", 16'h604C, 32'h5);
    chk("code point", 32'h5, {29'h0, cp_prio});
  endtask

  // vlan entry, member, non-member and untag lookups
  task automatic t_vlan;
    vc(1'b0, 1'b0, 4'h0, 18'h0C005);
    vc(1'b1, 1'b0, 4'h0, 18'h00000);
    ck("vlan entry", 16'h6038, 32'h0C005);
    lk(2'h1, 1'b1, {2'h3, 3'h2, 3'h4, 12'h005, 3'h6});
    lk(2'h2, 1'b1, {2'h2, 3'h2, 3'h0, 12'h005, 3'h6});
    admit <= 3'h4;
    lk(2'h2, 1'b1, {2'h3, 3'h2, 3'h0, 12'h005, 3'h6});
  endtask

  // port defaults for untagged and null id frames
  task automatic t_default;
    vc(1'b0, 1'b1, 4'h2, 18'h03007);
    vc(1'b1, 1'b1, 4'h2, 18'h00000);
    ck("default entry", 16'h6038, 32'h3007);
    lk(2'h2, 1'b0, {2'h3, 3'h0, 3'h0, 12'h007, 3'h3});
    lkp_vid <= 12'h000;
    lk(2'h2, 1'b1, {2'h3, 3'h0, 3'h0, 12'h007, 3'h3});
  endtask

  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_pmap();
    t_vlan();
    t_default();
    summarize();
  end

  // watchdog, far beyond the fewer than a hundred cycles needed
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
